// ===== hdl/dcf_frontend.sv
// DDR SDRAM command front end: decode, bank tracking, modes, config registers.
`include "dcf_cfg.svh"
module dcf_frontend
   import dcf_pkg::*;
#(
   parameter int DSIZE               = 32,
   parameter int address_width_param = 24,
   parameter int RANKS               = 2,
   parameter int ROW_W               = 12,
   parameter int COL_W               = 8,
   parameter int FIFO_DEPTH          = 16
)(
   input  wire logic                           core_clk,
   input  wire logic                           rst_b,
   input  wire logic [2:0]                     cmd,
   input  wire logic [address_width_param-1:0] addr,
   output logic                                busy,
   input  wire logic [DSIZE-1:0]               datain,
   input  wire logic                           datain_valid,
   output logic                                datain_ready,
   output logic [DSIZE-1:0]                    dataout,
   output logic                                dataout_valid,
   output dcf_mem_cmd_t                        mem_cmd,
   output logic [RANKS-1:0]                    mem_cs_b,
   output logic [DSIZE-1:0]                    mem_dq_out,
   output logic                                mem_dq_oe,
   input  wire logic [DSIZE-1:0]               mem_dq_in,
   input  wire logic                           mem_rd_valid
);
   localparam int RK_W = (RANKS > 1) ? $clog2(RANKS) : 1;
   localparam int ABS  = ROW_W + 2 + COL_W;
   initial
   begin
      if (address_width_param < ABS + RK_W || address_width_param < 20 || ROW_W < 12)
         $error("dcf_frontend address fields do not fit");
   end
   ////////////////////////////////////////////////////////////////////////////
   // Pin inputs pass two flops before any logic reads them.
   logic [DSIZE-1:0] dq_s1;
   logic [DSIZE-1:0] dq_s2;
   logic             rv_s1;
   logic             rv_s2;
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dq_s1 <= '0;
         dq_s2 <= '0;
         rv_s1 <= 1'b0;
         rv_s2 <= 1'b0;
      end
      else
      begin
         dq_s1 <= mem_dq_in;
         dq_s2 <= dq_s1;
         rv_s1 <= mem_rd_valid;
         rv_s2 <= rv_s1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Write data is buffered so the user can run ahead of the memory.
   logic [DSIZE-1:0] wf_data;
   logic             wf_valid;
   logic             wf_pop;
   dcf_fifo #(.WIDTH(DSIZE), .DEPTH(FIFO_DEPTH)) u_wfifo (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .in_data   (datain),
      .in_valid  (datain_valid),   // Capture only while valid is high.
      .in_ready  (datain_ready),
      .out_data  (wf_data),
      .out_valid (wf_valid),
      .out_ready (wf_pop)
   );
   ////////////////////////////////////////////////////////////////////////////
   // All sequencer state in one struct.
   typedef struct packed {
      dcf_state_t        st;
      dcf_state_t        ret;
      logic [17:0]       timing_mode_config;
      logic [17:0]       delay_config_a;
      logic [17:0]       refresh_period_config;
      logic [17:0]       delay_config_b;
      logic [3:0]        open_bank;
      logic [4*ROW_W-1:0] open_row;
      logic [RK_W-1:0]   cur_rank;
      logic [1:0]        cur_bank;
      logic [ROW_W-1:0]  cur_row;
      logic [COL_W-1:0]  cur_col;
      logic              cur_wr;
      logic [1:0]        mr_ba;
      logic [11:0]       mr_val;
      logic [15:0]       ref_cnt;
      logic              ref_due;
      logic [7:0]        wait_cnt;
      logic [3:0]        burst_left;
      logic              inited;
      logic              busy;
      dcf_mem_cmd_t      mc;
      logic [RANKS-1:0]  cs_b;
      logic [DSIZE-1:0]  dq_out;
      logic              dq_oe;
      logic [DSIZE-1:0]  dout;
      logic              dout_v;
   } dcf_regs_t;
   dcf_regs_t r;
   dcf_regs_t next_r;
   dcf_mem_cmd_t idle_cmd;
   assign idle_cmd = '{ras_b: 1'b1, cas_b: 1'b1, we_b: 1'b1, cke: 1'b1, ba: 2'h0,
                       addr: 12'h000};
   logic [3:0]       bl_words;
   logic             row_hit;
   logic [ROW_W-1:0] row_of_bank;
   // Burst length code to words; reserved codes fall back to two.
   always_comb
   begin
      case (r.timing_mode_config[2:0])
         `DCF_BL_4: bl_words = 4'h4;
         `DCF_BL_8: bl_words = 4'h8;
         default:   bl_words = 4'h2;
      endcase
   end
   assign row_of_bank = r.open_row[r.cur_bank*ROW_W +: ROW_W];
   assign row_hit     = r.open_bank[r.cur_bank] && (row_of_bank == r.cur_row);
   assign wf_pop      = (r.st == ST_WDATA) && wf_valid;
   ////////////////////////////////////////////////////////////////////////////
   // Command decode and memory sequencing.
   always_comb
   begin
      next_r        = r;
      next_r.mc     = idle_cmd;
      next_r.dout_v = 1'b0;
      next_r.dq_oe  = 1'b0;
      next_r.cs_b   = r.cs_b;
      // Refresh counter runs in normal and power-down modes.
      if (r.ref_cnt == 16'h0000)
      begin
         next_r.ref_cnt = r.refresh_period_config[15:0];
         if (r.inited && r.st != ST_SREF)
            next_r.ref_due = 1'b1;
      end
      else
         next_r.ref_cnt = r.ref_cnt - 16'h0001;
      // Read data returns with its valid flag.
      if (rv_s2)
      begin
         next_r.dout   = dq_s2;
         next_r.dout_v = 1'b1;
      end
      case (r.st)
         ST_IDLE:
         begin
            // A user command wins over a pending refresh, so a command given while
            // busy reads low is never lost; the refresh follows right after it.
            if (r.ref_due && (cmd == `DCF_CMD_NOP || cmd == `DCF_CMD_UNDEF))
            begin
               next_r.ret  = ST_IDLE;
               next_r.st   = ST_REF;
               next_r.busy = 1'b1;
            end
            else
            begin
               case (cmd)
                  `DCF_CMD_READ, `DCF_CMD_WRITE:
                  begin
                     if (r.inited)
                     begin
                        next_r.cur_wr   = (cmd == `DCF_CMD_WRITE);
                        next_r.cur_col  = addr[COL_W-1:0];
                        next_r.cur_bank = addr[COL_W +: 2];
                        next_r.cur_row  = addr[COL_W+2 +: ROW_W];
                        next_r.cur_rank = addr[ABS +: RK_W];
                        next_r.st       = ST_PRE;
                        next_r.busy     = 1'b1;
                     end
                  end
                  `DCF_CMD_LDCFG:  // Accepted even before init.
                  begin
                     case (addr[1:0])
                        `DCF_REG_TMC:
                        begin
                           next_r.timing_mode_config = addr[19:2];
                           next_r.mr_ba  = `DCF_MR_BASE;
                           next_r.mr_val = {5'h00, addr[8:2]};
                           if (addr[2+`DCF_INIT_BIT])
                           begin
                              next_r.busy     = 1'b1;
                              next_r.wait_cnt = `DCF_INIT_CYC;
                              next_r.st       = ST_INIT;
                           end
                           else if (r.inited)
                              next_r.st = ST_MRS;
                        end
                        `DCF_REG_DCA: next_r.delay_config_a = addr[19:2];
                        `DCF_REG_RPC:  // New period takes effect at once.
                        begin
                           next_r.refresh_period_config = addr[19:2];
                           next_r.ref_cnt               = addr[17:2];
                        end
                        default:      next_r.delay_config_b = addr[19:2];
                     endcase
                  end
                  `DCF_CMD_LDMR:
                  begin
                     next_r.mr_ba  = addr[13:12];
                     next_r.mr_val = addr[11:0];
                     if (addr[13:12] == `DCF_MR_BASE)
                        next_r.timing_mode_config[6:0] = addr[6:0];
                     next_r.busy = 1'b1;
                     next_r.st   = ST_MRS;
                  end
                  `DCF_CMD_SREF:  // All ranks enter self-refresh.
                  begin
                     next_r.mc       = '{ras_b: 1'b0, cas_b: 1'b0, we_b: 1'b1,
                                         cke: 1'b0, ba: 2'h0, addr: 12'h000};
                     next_r.cs_b     = '0;
                     next_r.open_bank = 4'h0;
                     next_r.ref_due  = 1'b0;  // Memory refreshes itself from here.
                     next_r.st       = ST_SREF;
                  end
                  `DCF_CMD_PDOWN:
                  begin
                     next_r.mc.cke = 1'b0;
                     next_r.cs_b   = '0;
                     next_r.st     = ST_PDOWN;
                  end
                  default: ;  // Codes 000 and 111 leave memory alone.
               endcase
            end
         end
         ST_INIT:
         begin
            // Settle, mark all banks closed without a precharge command, then load mode before declaring ready.
            next_r.cs_b = '0;
            if (r.wait_cnt == 8'h00)
            begin
               next_r.open_bank = 4'h0;
               next_r.inited    = 1'b1;
               next_r.st        = ST_MRS;
            end
            else
               next_r.wait_cnt = r.wait_cnt - 8'h01;
         end
         ST_PRE:
         begin
            // Precharge only if another row is open in this bank.
            next_r.cs_b = '1;
            next_r.cs_b[r.cur_rank] = 1'b0;
            if (row_hit)
               next_r.st = ST_RW;
            else if (r.open_bank[r.cur_bank])
            begin
               next_r.mc = '{ras_b: 1'b0, cas_b: 1'b1, we_b: 1'b0, cke: 1'b1,
                             ba: r.cur_bank, addr: 12'h000};
               next_r.open_bank[r.cur_bank] = 1'b0;
               next_r.wait_cnt = {5'h00, r.delay_config_a[12:10]};
               next_r.ret      = ST_ACT;
               next_r.st       = ST_WAIT;
            end
            else
               next_r.st = ST_ACT;
         end
         ST_ACT:
         begin
            next_r.mc = '{ras_b: 1'b0, cas_b: 1'b1, we_b: 1'b1, cke: 1'b1,
                          ba: r.cur_bank, addr: r.cur_row[11:0]};
            next_r.open_bank[r.cur_bank] = 1'b1;
            next_r.open_row[r.cur_bank*ROW_W +: ROW_W] = r.cur_row;
            next_r.wait_cnt = {5'h00, r.delay_config_a[2:0]};
            next_r.ret      = ST_RW;
            next_r.st       = ST_WAIT;
         end
         ST_RW:
         begin
            next_r.mc = '{ras_b: 1'b1, cas_b: 1'b0, we_b: !r.cur_wr, cke: 1'b1,
                          ba: r.cur_bank, addr: 12'(r.cur_col)};
            next_r.burst_left = bl_words;
            next_r.st   = r.cur_wr ? ST_WDATA : ST_IDLE;
            next_r.busy = r.cur_wr;
         end
         ST_WDATA:
         begin
            // Drain one word per cycle; stalls while the user lags.
            if (wf_valid)
            begin
               next_r.dq_out     = wf_data;
               next_r.dq_oe      = 1'b1;
               next_r.burst_left = r.burst_left - 4'h1;
               if (r.burst_left == 4'h1)
               begin
                  next_r.busy = 1'b0;
                  next_r.st   = ST_IDLE;
               end
            end
         end
         ST_MRS:
         begin
            next_r.cs_b = '0;
            next_r.mc = '{ras_b: 1'b0, cas_b: 1'b0, we_b: 1'b0, cke: 1'b1,
                          ba: r.mr_ba, addr: r.mr_val};
            next_r.wait_cnt = {5'h00, r.delay_config_a[15:13]};
            next_r.ret      = ST_IDLE;
            next_r.st       = ST_WAIT;
         end
         ST_REF:
         begin
            next_r.cs_b    = '0;
            next_r.mc      = '{ras_b: 1'b0, cas_b: 1'b0, we_b: 1'b1, cke: 1'b1,
                               ba: 2'h0, addr: 12'h000};
            next_r.open_bank = 4'h0;
            // A new period ending in this very cycle keeps its request pending.
            if (r.ref_cnt != 16'h0000)
               next_r.ref_due = 1'b0;
            next_r.wait_cnt = {4'h0, r.delay_config_a[9:6]};
            next_r.st       = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (r.wait_cnt == 8'h00)
            begin
               next_r.st   = r.ret;
               next_r.busy = (r.ret != ST_IDLE) && (r.ret != ST_PDOWN);
            end
            else
               next_r.wait_cnt = r.wait_cnt - 8'h01;
         end
         ST_SREF:
         begin
            next_r.mc.cke = 1'b0;
            if (cmd == `DCF_CMD_SREF)  // Only a repeat exits.
            begin
               next_r.mc.cke   = 1'b1;
               next_r.ref_cnt  = r.refresh_period_config[15:0];
               next_r.wait_cnt = {4'h0, r.delay_config_b[10:7]};
               next_r.ret      = ST_IDLE;
               next_r.st       = ST_WAIT;
            end
         end
         ST_PDOWN:
         begin
            next_r.mc.cke = 1'b0;
            if (cmd == `DCF_CMD_PDOWN)  // Repeat exits, others dropped.
            begin
               next_r.mc.cke = 1'b1;
               next_r.st     = ST_IDLE;
            end
            else if (r.ref_due)  // Wake for refresh, then sleep again.
            begin
               next_r.mc.cke   = 1'b1;
               next_r.wait_cnt = {4'h0, `DCF_STEP_CYC};
               next_r.st       = ST_PDWAKE;
            end
         end
         ST_PDWAKE:
         begin
            if (r.wait_cnt == 8'h00)
            begin
               next_r.ret = ST_PDOWN;
               next_r.st  = ST_REF;
            end
            else
               next_r.wait_cnt = r.wait_cnt - 8'h01;
         end
         default: next_r.st = ST_IDLE;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////
   // State register.
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         r                       <= '0;
         r.st                    <= ST_IDLE;
         r.ret                   <= ST_IDLE;
         r.timing_mode_config    <= `DCF_TMC_RST;
         r.delay_config_a        <= `DCF_DCA_RST;
         r.refresh_period_config <= `DCF_RPC_RST;
         r.delay_config_b        <= `DCF_DCB_RST;
         r.mc                    <= '{ras_b: 1'b1, cas_b: 1'b1, we_b: 1'b1, cke: 1'b0,
                                      ba: 2'h0, addr: 12'h000};
         r.cs_b                  <= '1;
      end
      else
         r <= next_r;
   end
   assign busy          = r.busy || r.ref_due;  // A pending refresh also holds the user off.
   assign dataout       = r.dout;
   assign dataout_valid = r.dout_v;
   assign mem_cmd       = r.mc;
   assign mem_cs_b      = r.cs_b;
   assign mem_dq_out    = r.dq_out;
   assign mem_dq_oe     = r.dq_oe;
   ////////////////////////////////////////////////////////////////////////////
   // Checks on the sequencing.
   sequence sref_entry_s;
      r.st == ST_IDLE && !r.ref_due && cmd == `DCF_CMD_SREF;
   endsequence
   sref_enter_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      sref_entry_s |=> r.st == ST_SREF && !mem_cmd.cke)
      else $error("self-refresh not entered");
   sref_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      r.st == ST_SREF && cmd != `DCF_CMD_SREF |=> r.st == ST_SREF)
      else $error("self-refresh left without command");
   sref_exit_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      r.st == ST_SREF && cmd == `DCF_CMD_SREF |=> r.st == ST_WAIT && mem_cmd.cke)
      else $error("self-refresh exit failed");
   pdown_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      r.st == ST_PDOWN && cmd != `DCF_CMD_PDOWN && !r.ref_due |=> r.st == ST_PDOWN)
      else $error("power-down left without command");
   nop_idle_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      r.st == ST_IDLE && !r.ref_due && (cmd == `DCF_CMD_NOP || cmd == `DCF_CMD_UNDEF)
      |=> r.st == ST_IDLE && mem_cmd.ras_b && mem_cmd.cas_b)
      else $error("no-op touched memory");
   cfg_load_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      r.st == ST_IDLE && !r.ref_due && cmd == `DCF_CMD_LDCFG && addr[1:0] == `DCF_REG_RPC
      |=> r.refresh_period_config == $past(addr[19:2]))
      else $error("config load lost");
   init_busy_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      r.st == ST_INIT |-> busy)
      else $error("busy low during init");
   rd_valid_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      rv_s2 |=> dataout_valid && dataout == $past(dq_s2))
      else $error("read data not returned");
   wr_capture_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      r.st == ST_WDATA && !wf_valid |=> !mem_dq_oe)
      else $error("write data driven without valid word");
endmodule

// ===== hdl/dcf_cfg.svh
// Constants for the DDR SDRAM command front end.
// Overview of operation
// - Code 000 does nothing to memory.
// - Read is code 001, rank plus address.
// - Read opens or closes rows itself.
// - Read data returned with valid flag.
// - Write is code 010, rank plus address.
// - Write opens or closes rows itself.
// - Write data captured only while valid.
// - Code 110 puts all ranks into self-refresh.
// - Second self-refresh command exits.
// - Self-refresh drops all other commands.
// - Code 100 loads mode register, bank bits.
// - Bank 00 base, 01 extended mode register.
// - Base mode load updates first config register.
// - Code 101 power-down, wakes for refresh.
// - Power-down exits on repeat, ignores others.
// - Code 011 writes config, address 1:0 selects.
// - Address 19:2 carries config data.
// - Config loads accepted before initialization.
// - First config write reprograms mode register.
// - Init bit starts init, busy until done.
// - Low three bits encode burst 2/4/8.
// - Auto-refresh at third config interval.
`ifndef DCF_CFG_SVH
`define DCF_CFG_SVH
`define DCF_CMD_NOP    3'h0
`define DCF_CMD_READ   3'h1
`define DCF_CMD_WRITE  3'h2
`define DCF_CMD_LDCFG  3'h3
`define DCF_CMD_LDMR   3'h4
`define DCF_CMD_PDOWN  3'h5
`define DCF_CMD_SREF   3'h6
`define DCF_CMD_UNDEF  3'h7
`define DCF_REG_TMC    2'h0
`define DCF_REG_DCA    2'h1
`define DCF_REG_RPC    2'h2
`define DCF_REG_DCB    2'h3
`define DCF_INIT_BIT   7
`define DCF_BL_2       3'h1
`define DCF_BL_4       3'h2
`define DCF_BL_8       3'h3
`define DCF_TMC_RST    18'h00022
`define DCF_DCA_RST    18'h00000
`define DCF_RPC_RST    18'h00400
`define DCF_DCB_RST    18'h00000
`define DCF_MR_BASE    2'h0
`define DCF_MR_EXT     2'h1
`define DCF_INIT_CYC   8'h20
`define DCF_STEP_CYC   4'h2
`endif

// ===== hdl/dcf_pkg.sv
// Types shared by the command front end.
package dcf_pkg;
   // Memory command pins; ras_b, cas_b and we_b active low, cke active high.
   typedef struct packed {
      logic       ras_b;
      logic       cas_b;
      logic       we_b;
      logic       cke;
      logic [1:0] ba;
      logic [11:0] addr;
   } dcf_mem_cmd_t;
   typedef enum logic [3:0] {
      ST_IDLE, ST_INIT, ST_PRE, ST_ACT, ST_RW, ST_WDATA, ST_MRS, ST_REF,
      ST_SREF, ST_PDOWN, ST_PDWAKE, ST_WAIT
   } dcf_state_t;
endpackage

// ===== hdl/dcf_fifo.sv
// Valid/ready FIFO of flip-flops with parameter width and depth.
module dcf_fifo
   import dcf_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
)(
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("dcf_fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   // Full when pointers differ only in the wrap bit.
   assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data  = mem[rd_ptr[AW-1:0]];
   // Pointers advance on each completed handshake.
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (in_valid && in_ready)
            wr_ptr <= wr_ptr + 1'b1;
         if (out_valid && out_ready)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
   // Storage has no reset; only written slots are ever read.
   always_ff @(posedge core_clk)
   begin
      if (in_valid && in_ready)
         mem[wr_ptr[AW-1:0]] <= in_data;
   end
endmodule

// ===== bench/dcf_mem_model.sv
// Behavioural DDR memory ranks facing the command front end.
module dcf_mem_model
   import dcf_pkg::*;
(
   input  wire logic         core_clk,
   input  wire dcf_mem_cmd_t mem_cmd,
   input  wire logic [1:0]   mem_cs_b,
   input  wire logic [31:0]  mem_dq_out,
   input  wire logic         mem_dq_oe,
   output logic      [31:0]  mem_dq_in,
   output logic              mem_rd_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [256];
   logic [7:0]  wptr;
   logic [7:0]  rptr;
   logic [3:0]  blen = 4'h4;
   logic [3:0]  left = 4'h0;
   logic [3:0]  lat = 4'h0;
   logic        sel;
   // Commands count only while some rank is selected.
   assign sel = ~&mem_cs_b;
   initial mem_dq_in = 32'h0;
   ////////////////////////////////////////////////////////////
   // Idle data lines toggle every cycle, so a stale word never looks like data.
   always @(posedge core_clk)
   begin
      if (sel && !mem_cmd.ras_b && !mem_cmd.cas_b && !mem_cmd.we_b && mem_cmd.ba == 2'h0)
         blen <= 4'h1 << mem_cmd.addr[2:0];
      if (sel && mem_cmd.ras_b && !mem_cmd.cas_b && !mem_cmd.we_b)
         wptr <= mem_cmd.addr[7:0];
      else if (mem_dq_oe)
      begin
         mem[wptr] <= mem_dq_out;
         wptr <= wptr + 8'h1;
      end
      mem_rd_valid <= 1'b0;
      mem_dq_in <= ~mem_dq_in;
      if (sel && mem_cmd.ras_b && !mem_cmd.cas_b && mem_cmd.we_b)
      begin
         rptr <= mem_cmd.addr[7:0];
         left <= blen;
         lat <= 4'h2;
      end
      else if (lat != 4'h0)
         lat <= lat - 4'h1;
      else if (left != 4'h0)
      begin
         mem_rd_valid <= 1'b1;
         mem_dq_in <= mem[rptr];
         rptr <= rptr + 8'h1;
         left <= left - 4'h1;
      end
   end
endmodule

// ===== bench/ddr_sdram_command_frontend_tb_top.sv
// Self-checking bench of the DDR SDRAM command front end.
module ddr_sdram_command_frontend_tb_top
   import dcf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic         core_clk, rst_b, busy, datain_valid, datain_ready;
   logic         dataout_valid, mem_dq_oe, mem_rd_valid;
   logic [2:0]   cmd;
   logic [23:0]  addr;
   logic [31:0]  datain, dataout, mem_dq_out, mem_dq_in, exp_b;
   logic [1:0]   mem_cs_b, cs_exp;
   dcf_mem_cmd_t mem_cmd;
   int           miscompares, n_tests, cyc, k, r, bcyc;
   // Each row: address, then the first word of its four-word burst.
   logic [55:0]  rows [5] = '{56'h000410_A0000000, 56'h000420_B1000000,
      56'h000830_C2000000, 56'h000540_D3000000, 56'h400E50_E4000000};
   dcf_frontend DUT (.core_clk, .rst_b, .cmd, .addr, .busy, .datain, .datain_valid,
      .datain_ready, .dataout, .dataout_valid, .mem_cmd, .mem_cs_b, .mem_dq_out,
      .mem_dq_oe, .mem_dq_in, .mem_rd_valid);
   dcf_mem_model MEM (.core_clk, .mem_cmd, .mem_cs_b, .mem_dq_out, .mem_dq_oe,
      .mem_dq_in, .mem_rd_valid);
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Busy cycles are counted so that a long operation is told from a dropped one.
   task automatic issue(input logic [2:0] c, input logic [23:0] a);
      bcyc = 0;
      cs_exp = ~(2'h1 << a[22]);
      for (int i = 0; i < 400 && busy !== 1'b0; i++)
         @(posedge core_clk);
      cmd <= c;
      addr <= a;
      @(posedge core_clk);
      cmd <= 3'h0;
      repeat (2) @(posedge core_clk);
      while (busy !== 1'b0 && bcyc < 400)
      begin
         @(posedge core_clk);
         bcyc++;
      end
   endtask
   task automatic push(input int n, input logic [31:0] b);
      @(posedge core_clk);
      for (int i = 0; i < n; i++)
      begin
         datain <= b + i;
         datain_valid <= 1'b1;
         do
            @(posedge core_clk);
         while (datain_ready !== 1'b1);
      end
      datain_valid <= 1'b0;
   endtask
   task automatic rd(input logic [23:0] a, input int n, input logic [31:0] b);
      k = 0;
      exp_b = b;
      issue(3'h1, a);
      repeat (20) @(posedge core_clk);
      chk(k, n);
   endtask
   ////////////////////////////////////////////////////////////
   // Clock, hang limit, and a monitor of read words and column chip selects.
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cyc++;
      if (dataout_valid === 1'b1)
      begin
         chk(dataout, exp_b + k);
         k++;
      end
      if (mem_cmd.ras_b === 1'b1 && mem_cmd.cas_b === 1'b0)
         chk({30'h0, mem_cs_b}, {30'h0, cs_exp});
      if (cyc == 20000)
      begin
         miscompares++;
         finish_test();
      end
   end
   initial
   begin
      rst_b = 1'b0;
      cmd = 3'h0;
      addr = 24'h0;
      datain = 32'h0;
      datain_valid = 1'b0;
      repeat (12) @(posedge core_clk);
      chk({28'h0, busy, mem_cmd.cke, mem_dq_oe, dataout_valid}, 32'h0);
      chk({30'h0, mem_cs_b}, 32'h3);
      rst_b <= 1'b1;
      rd(24'h000410, 0, 32'h0);
      issue(3'h3, 24'h000288);
      chk({31'h0, bcyc > 32}, 32'h1);
      $display("Test reset and init done");
      foreach (rows[i])
      begin
         push(4, rows[i][31:0]);
         issue(3'h2, rows[i][55:32]);
         rd(rows[i][55:32], 4, rows[i][31:0]);
      end
      $display("Test row table done");
      issue(3'h4, 24'h000001);
      issue(3'h4, 24'h001000);
      push(2, 32'h5A000000);
      issue(3'h2, 24'h000460);
      rd(24'h000460, 2, 32'h5A000000);
      issue(3'h3, 24'h00000C);
      push(16, 32'h6B000000);
      @(posedge core_clk);
      chk({31'h0, datain_ready}, 32'h0);
      issue(3'h2, 24'h000480);
      issue(3'h2, 24'h000488);
      rd(24'h000480, 8, 32'h6B000000);
      rd(24'h000488, 8, 32'h6B000008);
      $display("Test burst and buffer done");
      for (int c = 5; c < 7; c++)
      begin
         issue(3'(c), 24'h0);
         if (c == 6)
            chk({31'h0, mem_cmd.cke}, 32'h0);
         rd(24'h000480, 0, 32'h0);
         issue(3'(c), 24'h0);
         rd(24'h000480, 8, 32'h6B000000);
      end
      issue(3'h7, 24'hFFFFFF);
      chk(bcyc, 32'h0);
      issue(3'h0, 24'hFFFFFF);
      chk(bcyc, 32'h0);
      issue(3'h3, 24'h000102);
      repeat (256)
      begin
         @(posedge core_clk);
         if (mem_cmd.ras_b === 1'b0 && mem_cmd.cas_b === 1'b0 && mem_cmd.we_b === 1'b1)
            r++;
      end
      chk({31'h0, r > 2 && r < 6}, 32'h1);
      $display("Test modes and refresh done");
      finish_test();
   end
endmodule
